// file: pkg/rcf_pkg.sv
// Constants and types for the reset cause flag block.
`default_nettype none
package rcf_pkg;
  localparam logic [7:0]  RCF_OFF_CAUSE    = 8'h00;
  localparam logic [7:0]  RCF_OFF_EVT      = 8'h04;
  localparam logic [7:0]  RCF_OFF_MASK     = 8'h08;
  localparam int unsigned RCF_POS_STK_OVF  = 7;
  localparam int unsigned RCF_POS_STK_UNF  = 6;
  localparam int unsigned RCF_POS_UNUSED   = 5;
  localparam int unsigned RCF_POS_WDT      = 4;
  localparam int unsigned RCF_POS_PIN      = 3;
  localparam int unsigned RCF_POS_INSTR    = 2;
  localparam int unsigned RCF_POS_PWR_ON   = 1;
  localparam int unsigned RCF_POS_BROWNOUT = 0;
  localparam logic [7:0]  RCF_CAUSE_RST    = 8'h1C;
  localparam logic [7:0]  RCF_CAUSE_IMPL   = 8'hDF;
  localparam logic [7:0]  RCF_ACTIVE_HIGH  = 8'hC0;
  localparam logic [7:0]  RCF_ACTIVE_LOW   = 8'h1F;
  localparam logic [7:0]  RCF_EVT_RST      = 8'h00;
  localparam logic [7:0]  RCF_MASK_RST     = 8'h00;
  localparam logic [1:0]  RCF_PIN_SYNC_RST = 2'h3;
  localparam logic [2:0]  RCF_HSIZE_WORD   = 3'h2;
  localparam logic [31:0] RCF_RDATA_RST    = 32'h0000_0000;

  typedef struct packed {
    logic stack_overflow;
    logic stack_underflow;
    logic watchdog;
    logic reset_instr;
    logic power_on;
    logic brownout;
  } rcf_cause_evt_t;

  typedef enum logic [1:0] {
    RCF_BUS_IDLE  = 2'b01,
    RCF_BUS_WPEND = 2'b10
  } rcf_bus_state_t;
endpackage : rcf_pkg
`default_nettype wire

// file: rtl/rcf_reset_cause_flags.sv
// Reset cause flag register with interrupt reporting on an AHB-Lite slave.
//
// Behaviour
// - A stack underflow event sets bit 6; it reads zero otherwise or once cleared.
// - Bit 5 and unmapped locations read zero and ignore writes.
// - A pin reset clears bit 3; it reads one otherwise or after software sets it.
// - A reset instruction clears bit 2; it reads one otherwise or after a write.
// - Power-on clears bit 1; software sets it afterwards to tell resets apart.
// - Each event updates only its own flag, except power-on, which also clears bit 0; all others keep their value.
// - Hardware never returns a flag to inactive; software restores it.
// - Writing a flag active only stores the bit and starts no reset.
`timescale 1ns/1ps
`default_nettype none
module rcf_reset_cause_flags (
  input  wire logic                    hclk,
  input  wire logic                    hresetn,
  input  wire logic                    ce,
  input  wire logic                    hsel,
  input  wire logic [31:0]             haddr,
  input  wire logic [1:0]              htrans,
  input  wire logic                    hwrite,
  input  wire logic [2:0]              hsize,
  input  wire logic [31:0]             hwdata,
  input  wire logic                    hready,
  output logic      [31:0]             hrdata,
  output logic                         hreadyout,
  output logic                         hresp,
  input  wire rcf_pkg::rcf_cause_evt_t cause_evt,
  input  wire logic                    external_reset_pin_n,
  output logic      [7:0]              cause_flags,
  output logic                         irq
);
  import rcf_pkg::*;

  // One-hot register select: cause, event status, mask.
  function automatic logic [2:0] rcf_decode(input logic [31:0] addr);
    logic [2:0] sel;
    sel = 3'h0;
    if (addr[31:8] == 24'h00_0000) begin
      sel[0] = (addr[7:0] == RCF_OFF_CAUSE);
      sel[1] = (addr[7:0] == RCF_OFF_EVT);
      sel[2] = (addr[7:0] == RCF_OFF_MASK);
    end
    return sel;
  endfunction : rcf_decode

  // Maps cause inputs onto the flag layout; power-on also counts as brown-out.
  function automatic logic [7:0] rcf_evt_vec(input rcf_cause_evt_t e,
                                             input logic           pin);
    logic [7:0] v;
    v = 8'h00;
    v[RCF_POS_STK_OVF]  = e.stack_overflow;
    v[RCF_POS_STK_UNF]  = e.stack_underflow;
    v[RCF_POS_WDT]      = e.watchdog;
    v[RCF_POS_PIN]      = pin;
    v[RCF_POS_INSTR]    = e.reset_instr;
    v[RCF_POS_PWR_ON]   = e.power_on;
    v[RCF_POS_BROWNOUT] = e.brownout | e.power_on;
    return v;
  endfunction : rcf_evt_vec

  rcf_bus_state_t state_q;
  logic [2:0]     wsel_q;
  logic [31:0]    hrdata_q;
  logic           hreadyout_q;
  logic           hresp_q;
  logic [7:0]     cause_q;
  logic [7:0]     cause_d;
  logic [7:0]     evt_q;
  logic [7:0]     evt_d;
  logic [7:0]     mask_q;
  logic           irq_q;
  logic [1:0]     pin_sync_q;
  logic           pin_prev_q;
  logic           pin_evt;
  logic [7:0]     hw_evt;
  logic           acc;
  logic [2:0]     asel;
  logic           wr_cause;
  logic           wr_evt;
  logic           wr_mask;

  assign hrdata      = hrdata_q;
  assign hreadyout   = hreadyout_q;
  assign hresp       = hresp_q;
  assign cause_flags = cause_q;
  assign irq         = irq_q;

  assign acc  = ce && hsel && hready && htrans[1];
  assign asel = rcf_decode(haddr);

  // Writes take one wait state so the data phase lands before any later read.
  assign wr_cause = ce && (state_q == RCF_BUS_WPEND) && wsel_q[0];
  assign wr_evt   = ce && (state_q == RCF_BUS_WPEND) && wsel_q[1];
  assign wr_mask  = ce && (state_q == RCF_BUS_WPEND) && wsel_q[2];

  // The pin is asynchronous; its falling edge is seen only after two stages.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_sync_q <= RCF_PIN_SYNC_RST;
      pin_prev_q <= 1'b1;
    end else if (ce) begin
      pin_sync_q <= {pin_sync_q[0], external_reset_pin_n};
      pin_prev_q <= pin_sync_q[1];
    end
  end

  assign pin_evt = pin_prev_q && !pin_sync_q[1];
  assign hw_evt  = ce ? rcf_evt_vec(cause_evt, pin_evt) : 8'h00;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q     <= RCF_BUS_IDLE;
      wsel_q      <= 3'h0;
      hreadyout_q <= 1'b1;
      hresp_q     <= 1'b0;
    end else if (ce) begin
      hresp_q <= 1'b0;
      case (state_q)
        RCF_BUS_IDLE: begin
          if (acc && hwrite) begin
            state_q     <= RCF_BUS_WPEND;
            hreadyout_q <= 1'b0;
            // Sub-word writes are completed but store nothing.
            wsel_q      <= (hsize == RCF_HSIZE_WORD) ? asel : 3'h0;
          end
        end
        RCF_BUS_WPEND: begin
          state_q     <= RCF_BUS_IDLE;
          hreadyout_q <= 1'b1;
          wsel_q      <= 3'h0;
        end
        default: begin
          state_q     <= RCF_BUS_IDLE;
          hreadyout_q <= 1'b1;
          wsel_q      <= 3'h0;
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= RCF_RDATA_RST;
    end else if (ce && acc && !hwrite) begin
      hrdata_q <= 32'h0000_0000;
      if (asel[0]) begin
        hrdata_q[7:0] <= cause_q & RCF_CAUSE_IMPL;
      end else if (asel[1]) begin
        hrdata_q[7:0] <= evt_q;
      end else if (asel[2]) begin
        hrdata_q[7:0] <= mask_q;
      end
    end
  end

  // A hardware event overrides a software write to the same flag.
  always_comb begin
    cause_d = cause_q;
    for (int i = 0; i < 8; i++) begin
      if (hw_evt[i]) begin
        cause_d[i] = RCF_ACTIVE_HIGH[i];
      end else if (wr_cause) begin
        cause_d[i] = hwdata[i];
      end
    end
    cause_d = cause_d & RCF_CAUSE_IMPL;
  end

  // This register stands for the power-on state, so nothing but hresetn reloads it.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cause_q <= RCF_CAUSE_RST;
    end else if (ce) begin
      cause_q <= cause_d;
    end
  end

  always_comb begin
    evt_d = evt_q;
    if (wr_evt) begin
      evt_d = evt_q & ~hwdata[7:0];
    end
    evt_d = (evt_d | hw_evt) & RCF_CAUSE_IMPL;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      evt_q <= RCF_EVT_RST;
    end else if (ce) begin
      evt_q <= evt_d;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mask_q <= RCF_MASK_RST;
    end else if (wr_mask) begin
      mask_q <= hwdata[7:0] & RCF_CAUSE_IMPL;
    end
  end

  // The interrupt follows status and mask one cycle late to stay a flop output.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_q <= 1'b0;
    end else if (ce) begin
      irq_q <= |(evt_q & mask_q);
    end
  end

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  property p_stk_ovf;
    (ce && cause_evt.stack_overflow) |=> cause_q[RCF_POS_STK_OVF];
  endproperty
  a_stk_ovf: assert property (p_stk_ovf) else $error("overflow flag not set");

  property p_stk_unf;
    (ce && cause_evt.stack_underflow) |=> cause_q[RCF_POS_STK_UNF] && evt_q[RCF_POS_STK_UNF];
  endproperty
  a_stk_unf: assert property (p_stk_unf) else $error("underflow flag not set");

  property p_unused;
    (acc && !hwrite && (asel == 3'h0 || asel[0]))
      |=> (hrdata_q[31:8] == 24'h00_0000) && !hrdata_q[RCF_POS_UNUSED] && !cause_q[RCF_POS_UNUSED];
  endproperty
  a_unused: assert property (p_unused) else $error("unused bits not zero");

  property p_pin;
    (ce && $fell(pin_sync_q[1])) |=> !cause_q[RCF_POS_PIN];
  endproperty
  a_pin: assert property (p_pin) else $error("pin reset flag not cleared");

  property p_instr;
    (ce && cause_evt.reset_instr) |=> !cause_q[RCF_POS_INSTR];
  endproperty
  a_instr: assert property (p_instr) else $error("instruction flag not cleared");

  property p_pwr_on;
    (ce && cause_evt.power_on) |=> !cause_q[RCF_POS_PWR_ON] && !cause_q[RCF_POS_BROWNOUT];
  endproperty
  a_pwr_on: assert property (p_pwr_on) else $error("power-on flags not cleared");

  property p_wdt_bor;
    (ce && (cause_evt.watchdog || cause_evt.brownout))
      |=> (!cause_q[RCF_POS_WDT] || !$past(cause_evt.watchdog))
       && (!cause_q[RCF_POS_BROWNOUT] || !$past(cause_evt.brownout));
  endproperty
  a_wdt_bor: assert property (p_wdt_bor) else $error("watchdog or brown-out flag wrong");

  property p_keep;
    (!wr_cause && hw_evt == 8'h00) |=> $stable(cause_q);
  endproperty
  a_keep: assert property (p_keep) else $error("flag changed without its cause");

  property p_no_self_clear;
    !wr_cause |=> (((cause_q & ~$past(cause_q)) & RCF_ACTIVE_LOW) == 8'h00)
               && (((~cause_q & $past(cause_q)) & RCF_ACTIVE_HIGH) == 8'h00);
  endproperty
  a_no_self_clear: assert property (p_no_self_clear) else $error("flag went inactive");

  property p_sw_write;
    (wr_cause && hw_evt == 8'h00)
      |=> (cause_q == ($past(hwdata[7:0]) & RCF_CAUSE_IMPL)) && (evt_q == $past(evt_q));
  endproperty
  a_sw_write: assert property (p_sw_write) else $error("write not stored plainly");

  property p_irq;
    (ce && $past(ce) && (evt_q & mask_q) != 8'h00) |=> irq_q;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised");

  property p_write_wait;
    (acc && hwrite) |=> !hreadyout_q ##1 hreadyout_q;
  endproperty
  a_write_wait: assert property (p_write_wait) else $error("write wait state wrong");

endmodule : rcf_reset_cause_flags
`default_nettype wire

// file: tb/rcf_tb_top.sv
// Self-checking testbench for the reset cause flag block.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import rcf_pkg::*;
  localparam logic [5:0] EV  [5] = '{6'h20, 6'h10, 6'h08, 6'h04, 6'h02};
  localparam logic [7:0] EXP [5] = '{8'h9F, 8'hDF, 8'hCF, 8'hCB, 8'hC8};
  logic           hclk         = 1'b0;
  logic           hresetn      = 1'b0;
  logic           ce           = 1'b1;
  logic           hsel         = 1'b0;
  logic [31:0]    haddr        = 32'h0000_0000;
  logic [1:0]     htrans       = 2'h0;
  logic           hwrite       = 1'b0;
  logic [31:0]    hwdata       = 32'h0000_0000;
  logic [31:0]    hrdata;
  logic           hreadyout;
  logic           hresp;
  rcf_cause_evt_t cause_evt    = '0;
  logic           pin_n        = 1'b1;
  logic [7:0]     cause_flags;
  logic [31:0]    flags32;
  logic           irq;
  logic [31:0]    rd;
  int             num_errors   = 0;
  int             total_checks = 0;
  int             cycles       = 0;

  assign flags32 = {24'h00_0000, cause_flags};

  always #5 hclk = ~hclk;

  rcf_reset_cause_flags rcf_reset_cause_flags_inst (
    .hclk                 (hclk),
    .hresetn              (hresetn),
    .ce                   (ce),
    .hsel                 (hsel),
    .haddr                (haddr),
    .htrans               (htrans),
    .hwrite               (hwrite),
    .hsize                (RCF_HSIZE_WORD),
    .hwdata               (hwdata),
    .hready               (hreadyout),
    .hrdata               (hrdata),
    .hreadyout            (hreadyout),
    .hresp                (hresp),
    .cause_evt            (cause_evt),
    .external_reset_pin_n (pin_n),
    .cause_flags          (cause_flags),
    .irq                  (irq)
  );

  task close_out;
    $display("Checks %0d, errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : close_out

  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      num_errors++;
      close_out();
    end
  end

  task check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  // The loop reads hreadyout before the edge's updates land, as the master samples it.
  task wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    check({31'h0, hreadyout}, 32'h0000_0001);
  endtask : wait_rdy

  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= {24'h00_0000, a};
    htrans <= 2'h2;
    hwrite <= w;
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
    check({31'h0, hresp}, 32'h0000_0000);
  endtask : bus

  task rchk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    check(rd, exp);
  endtask : rchk

  // A single high cycle counts as exactly one event.
  task pulse(input logic [5:0] v);
    cause_evt <= rcf_cause_evt_t'(v);
    @(posedge hclk);
    cause_evt <= '0;
    @(posedge hclk);
  endtask : pulse

  task t_reset;
    check(flags32, 32'h0000_001C);
    check({31'h0, irq}, 32'h0000_0000);
    rchk(RCF_OFF_CAUSE, 32'h0000_001C);
  endtask : t_reset

  task t_events;
    bus(1'b1, RCF_OFF_CAUSE, 32'h0000_001F);
    for (int i = 0; i < 5; i++) begin
      pulse(EV[i]);
      check(flags32, {24'h00_0000, EXP[i]});
    end
    bus(1'b1, RCF_OFF_CAUSE, 32'h0000_001F);
    pulse(6'h01);
    check(flags32, 32'h0000_001E);
    rchk(RCF_OFF_EVT, 32'h0000_00D7);
  endtask : t_events

  task t_pin;
    pin_n <= 1'b0;
    repeat (6) @(posedge hclk);
    check(flags32, 32'h0000_0016);
    pin_n <= 1'b1;
    repeat (6) @(posedge hclk);
    check(flags32, 32'h0000_0016);
    rchk(RCF_OFF_EVT, 32'h0000_00DF);
  endtask : t_pin

  task t_irq;
    check({31'h0, irq}, 32'h0000_0000);
    bus(1'b1, RCF_OFF_MASK, 32'h0000_0008);
    repeat (2) @(posedge hclk);
    check({31'h0, irq}, 32'h0000_0001);
    bus(1'b1, RCF_OFF_EVT, 32'h0000_0008);
    repeat (2) @(posedge hclk);
    check({31'h0, irq}, 32'h0000_0000);
    rchk(RCF_OFF_EVT, 32'h0000_00D7);
    bus(1'b1, RCF_OFF_EVT, 32'h0000_00FF);
    rchk(RCF_OFF_EVT, 32'h0000_0000);
    rchk(RCF_OFF_MASK, 32'h0000_0008);
  endtask : t_irq

  task t_soft;
    bus(1'b1, RCF_OFF_CAUSE, 32'h0000_00FF);
    rchk(RCF_OFF_CAUSE, 32'h0000_00DF);
    rchk(RCF_OFF_EVT, 32'h0000_0000);
    check({31'h0, irq}, 32'h0000_0000);
    repeat (20) @(posedge hclk);
    check(flags32, 32'h0000_00DF);
    bus(1'b1, 8'h0C, 32'h0000_0000);
    rchk(8'h0C, 32'h0000_0000);
    rchk(RCF_OFF_CAUSE, 32'h0000_00DF);
  endtask : t_soft

  // Events offered while the enable is low must leave every register untouched.
  task t_freeze;
    ce        <= 1'b0;
    cause_evt <= rcf_cause_evt_t'(6'h3F);
    repeat (3) @(posedge hclk);
    check(flags32, 32'h0000_00DF);
    ce        <= 1'b1;
    cause_evt <= '0;
    @(posedge hclk);
    check(flags32, 32'h0000_00DF);
    check({31'h0, irq}, 32'h0000_0000);
    rchk(RCF_OFF_EVT, 32'h0000_0000);
  endtask : t_freeze

  initial begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_events();
    t_pin();
    t_irq();
    t_soft();
    t_freeze();
    close_out();
  end
endmodule : tb_top
`default_nettype wire
